// *** rtl/ccmg_map.svh ***
// Constant map of the CPU clock mode generator
`ifndef CCMG_MAP_SVH
`define CCMG_MAP_SVH
// Strap codes
`define CCMG_CODE_X4      3'h7
`define CCMG_CODE_X3      3'h6
`define CCMG_CODE_X2      3'h5
`define CCMG_CODE_X5      3'h4
`define CCMG_CODE_DIRECT  3'h3
`define CCMG_CODE_X15     3'h2
`define CCMG_CODE_PRESC   3'h1
`define CCMG_CODE_X25     3'h0
// Twice the multiply factor per strap code
`define CCMG_F2_X4        4'h8
`define CCMG_F2_X3        4'h6
`define CCMG_F2_X2        4'h4
`define CCMG_F2_X5        4'ha
`define CCMG_F2_X15       4'h3
`define CCMG_F2_X25       4'h5
// Register byte offsets
`define CCMG_REG_CTRL     4'h0
`define CCMG_REG_STATUS   4'h4
`define CCMG_REG_HALF     4'h8
// Field positions, reset values and lock tolerance
`define CCMG_CTRL_GAIN_LSB 0
`define CCMG_ST_STRAP_LSB  0
`define CCMG_ST_OWE        3
`define CCMG_ST_MODE_LSB   4
`define CCMG_ST_LOCK       6
`define CCMG_GAIN_RST      2'h2
`define CCMG_LOCK_TOL      4'h4
`endif

// *** rtl/ccmg_pkg.sv ***
// Types and decode functions of the CPU clock mode generator
`default_nettype none
`include "ccmg_map.svh"
package ccmg_pkg;
   typedef enum logic [1:0] {CCMG_PLL, CCMG_DIRECT, CCMG_PRESC} ccmg_mode_e;

   // Clock path chosen by strap code and watchdog level
   function automatic ccmg_mode_e ccmg_mode_of(input logic [2:0] code, input logic oscillator_watchdog_enable);
      ccmg_mode_e m;
      m = CCMG_PLL;
      if (code == `CCMG_CODE_PRESC) m = CCMG_PRESC;
      else if (code == `CCMG_CODE_DIRECT || !oscillator_watchdog_enable) m = CCMG_DIRECT;
      return m;
   endfunction

   // Twice the multiply factor, so fractional factors stay integer
   function automatic logic [3:0] ccmg_f2(input logic [2:0] code);
      logic [3:0] f;
      case (code)
         `CCMG_CODE_X4:  f = `CCMG_F2_X4;
         `CCMG_CODE_X3:  f = `CCMG_F2_X3;
         `CCMG_CODE_X2:  f = `CCMG_F2_X2;
         `CCMG_CODE_X5:  f = `CCMG_F2_X5;
         `CCMG_CODE_X15: f = `CCMG_F2_X15;
         default:        f = `CCMG_F2_X25;
      endcase
      return f;
   endfunction

   // Input transitions per resync window: F, or 4F when F is fractional
   function automatic logic [4:0] ccmg_win(input logic [3:0] f2);
      return f2[0] ? {f2, 1'b0} : {2'h0, f2[3:1]};
   endfunction

   // CPU half-periods per resync window
   function automatic logic [5:0] ccmg_halfs(input logic [3:0] f2);
      logic [8:0] p;
      p = 9'(ccmg_win(f2)) * 9'(f2);
      return p[6:1];
   endfunction
endpackage
`default_nettype wire

// *** rtl/ccmg_pll_if.sv ***
// Link between the mode logic and the locked-loop synthesiser
`default_nettype none
interface ccmg_pll_if;
   logic       en;
   logic       trans;
   logic [4:0] win;
   logic [5:0] halfs;
   logic [1:0] gain;
   logic       tog;
   logic       locked;
   logic       sync;
   modport ctl (output en, trans, win, halfs, gain, input tog, locked, sync);
   modport pll (input en, trans, win, halfs, gain, output tog, locked, sync);
endinterface
`default_nettype wire

// *** rtl/ccmg_pll.sv ***
// Digital locked-loop synthesiser: rate accumulator trimmed once per window
`default_nettype none
`include "ccmg_map.svh"
module ccmg_pll
   import ccmg_pkg::*;
#(
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Mode logic side
   ccmg_pll_if.pll  p
);
   typedef struct packed {
      logic [CW:0]   acc;
      logic [CW-1:0] lest;
      logic [CW-1:0] meas;
      logic [4:0]    tcnt;
      logic          armed;
      logic          seen;
      logic          tog;
      logic          locked;
      logic          sync;
   } ccmg_pll_s;

   ccmg_pll_s     q;
   ccmg_pll_s     d;
   logic [CW-1:0] took;
   logic [CW:0]   diff;
   logic [CW:0]   step;
   logic [CW:0]   mag;
   logic [CW:0]   sum;

   // Next state: accumulator toggles halfs times per estimated window
   always_comb begin
      d = q;
      d.tog = 1'b0;
      d.sync = 1'b0;
      took = CW'(q.meas + 1'b1);
      diff = {1'b0, took} - {1'b0, q.lest};
      step = (CW+1)'($signed(diff) >>> p.gain);
      mag = diff[CW] ? (CW+1)'(-diff) : diff;
      sum = q.acc + (CW+1)'(p.halfs);
      if (q.seen) begin
         if (sum >= {1'b0, q.lest}) begin
            d.tog = 1'b1;
            sum = sum - {1'b0, q.lest};
         end
         d.acc = sum;
      end
      d.meas = (&q.meas) ? q.meas : took; // Saturate on a stopped input
      // Resync every window; the first window only arms, the second count is taken whole, later the error shifted right by gain
      if (p.trans) begin
         if (q.tcnt == p.win - 5'h1) begin
            d.tcnt = '0;
            d.sync = 1'b1;
            d.meas = '0;
            d.armed = 1'b1;
            if (q.armed && !q.seen) begin
               d.lest = took;
               d.seen = 1'b1;
            end else if (q.seen) begin
               d.lest = q.lest + step[CW-1:0];
               d.locked = mag <= (CW+1)'(`CCMG_LOCK_TOL);
            end
         end else begin
            d.tcnt = q.tcnt + 5'h1;
         end
      end
      if (!resetn_in || !p.en) d = '0;
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      q <= d;
   end

   assign p.tog = q.tog;
   assign p.locked = q.locked;
   assign p.sync = q.sync;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_sync_window;
      p.en && p.trans && q.tcnt == p.win - 5'h1 |=> q.sync;
   endproperty
   a_sync_window: assert property (p_sync_window)
      else $error("no resync after a full window of input transitions");

   property p_trim_only_at_sync;
      $changed(q.lest) && $past(p.en) && p.en |-> q.sync;
   endproperty
   a_trim_only_at_sync: assert property (p_trim_only_at_sync)
      else $error("rate estimate changed outside a resync");
endmodule
`default_nettype wire

// *** rtl/ccmg_top.sv ***
// CPU clock mode generator: strap capture, clock paths and register slave
`default_nettype none
`include "ccmg_map.svh"
// Summary of operation
// - The strap pins are sampled every reset cycle and the value seen at release selects the clock mode.
// - Codes 111, 110, 101 and 100 multiply the input by 4, 3, 2 and 5, with 111 the default.
// - Codes 011, 010, 001 and 000 give direct drive, times 1.5, divide by two and times 2.5.
// - Code 001 runs the CPU clock through a divide-by-two prescaler at half the input rate.
// - In prescaler mode each CPU clock phase lasts exactly one input period.
// - Code 011 switches the multiplier off and passes the input clock straight through.
// - In direct drive the CPU clock phases follow the input's own high and low times.
// - In direct drive two consecutive half-periods always add up to one input period.
// - A low watchdog enable forces direct drive in place of the multiplier.
// - All other codes enable the multiplier at the input rate times the selected factor.
// - The multiplier resynchronises to the input once every F input transitions, or every 4F when the factor F is fractional.
// - First resynchronisation only arms; the second takes the measured rate whole, each later one adds the error shifted right by gain, all of it at gain 0.
// - Both CPU clock edges are flagged so that either can launch pipeline or bus operations.
// - The clock half-period is the time between two CPU clock edges and is counted as such.
module ccmg_top
   import ccmg_pkg::*;
#(
   parameter int CW = 16,
   parameter int HW = 16
) (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // Oscillator and straps
   input  wire logic        oscillator_input_pin_in,
   input  wire logic [2:0]  clock_mode_strap_pins_in,
   input  wire logic        oscillator_watchdog_enable_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output var  logic [31:0] avs_readdata_out,
   output var  logic        avs_waitrequest_out,
   // CPU clock, phase markers and captured strap code
   output var  logic        cpu_clk_out,
   output var  logic        cpu_rise_out,
   output var  logic        cpu_fall_out,
   output var  logic        clock_half_period_out,
   output var  logic [2:0]  clock_mode_strap_bits_out
);
   typedef struct packed {
      logic [2:0]    strap;
      logic          oscillator_watchdog_enable;
      logic          osc;
      logic          cpu;
      logic          rise;
      logic          fall;
      logic          half_end;
      logic [HW-1:0] half_cnt;
      logic [1:0]    gain;
      logic          wreq;
      logic [31:0]   rdata;
   } ccmg_top_s;

   ccmg_top_s   s_q;
   ccmg_top_s   s_d;
   ccmg_mode_e  eff;
   logic [3:0]  f2;
   logic        osc_rise;
   logic [31:0] rd_word;
   logic [31:0] status;
   logic        pll_tog;
   logic        pll_locked;

   ccmg_pll_if pll_if ();

   // Mode in force; comes only from captured flops
   assign eff = ccmg_mode_of(s_q.strap, s_q.oscillator_watchdog_enable);
   assign f2 = ccmg_f2(s_q.strap);
   assign osc_rise = oscillator_input_pin_in & ~s_q.osc;

   // Synthesiser runs only when the multiplier path is selected
   assign pll_if.en = (eff == CCMG_PLL);
   assign pll_if.trans = oscillator_input_pin_in ^ s_q.osc;
   assign pll_if.win = ccmg_win(f2);
   assign pll_if.halfs = ccmg_halfs(f2);
   assign pll_if.gain = s_q.gain;
   assign pll_tog = pll_if.tog;
   assign pll_locked = pll_if.locked;

   ccmg_pll #(
      .CW (CW)
   ) u_pll (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .p          (pll_if.pll)
   );

   // Status word: captured code, watchdog level, mode, lock
   always_comb begin
      status = '0;
      status[`CCMG_ST_STRAP_LSB +: 3] = s_q.strap;
      status[`CCMG_ST_OWE] = s_q.oscillator_watchdog_enable;
      status[`CCMG_ST_MODE_LSB +: 2] = eff;
      status[`CCMG_ST_LOCK] = pll_locked;
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rd_word = '0;
      case (avs_address_in)
         `CCMG_REG_CTRL: rd_word[`CCMG_CTRL_GAIN_LSB +: 2] = s_q.gain;
         `CCMG_REG_STATUS: rd_word = status;
         `CCMG_REG_HALF: rd_word = 32'(s_q.half_cnt);
         default: rd_word = '0;
      endcase
   end

   // Next state of clock paths, phase markers and bus slave
   always_comb begin
      s_d = s_q;
      s_d.osc = oscillator_input_pin_in;
      s_d.rise = 1'b0;
      s_d.fall = 1'b0;
      s_d.half_end = 1'b0;
      case (eff)
         // Straight copy keeps each phase equal to the input phase
         CCMG_DIRECT: s_d.cpu = oscillator_input_pin_in;
         // Toggle on input rises: each phase is one input period
         CCMG_PRESC: begin
            if (osc_rise) s_d.cpu = ~s_q.cpu;
         end
         CCMG_PLL: begin
            if (pll_tog) s_d.cpu = ~s_q.cpu;
         end
         default: s_d.cpu = s_q.cpu;
      endcase
      // Both edges mark a half-period boundary
      if (s_d.cpu != s_q.cpu) begin
         s_d.rise = s_d.cpu;
         s_d.fall = ~s_d.cpu;
         s_d.half_end = 1'b1;
         s_d.half_cnt = s_q.half_cnt + 1'b1;
      end
      // One wait cycle per access; write lands at the answering edge
      if (s_q.wreq) begin
         if (avs_read_in || avs_write_in) begin
            s_d.wreq = 1'b0;
            s_d.rdata = avs_read_in ? rd_word : '0;
         end
      end else begin
         s_d.wreq = 1'b1;
         if (avs_write_in && avs_address_in == `CCMG_REG_CTRL && avs_byteenable_in[0]) begin
            s_d.gain = avs_writedata_in[`CCMG_CTRL_GAIN_LSB +: 2];
         end
      end
      // Straps are caught on every reset cycle, last one wins
      if (!resetn_in) begin
         s_d = '0;
         s_d.osc = oscillator_input_pin_in; // Tracks the pin so no false input edge follows release
         s_d.strap = clock_mode_strap_pins_in;
         s_d.oscillator_watchdog_enable = oscillator_watchdog_enable_in;
         s_d.gain = `CCMG_GAIN_RST;
         s_d.wreq = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      s_q <= s_d;
   end

   // Outputs straight from flops
   assign avs_readdata_out = s_q.rdata;
   assign avs_waitrequest_out = s_q.wreq;
   assign cpu_clk_out = s_q.cpu;
   assign cpu_rise_out = s_q.rise;
   assign cpu_fall_out = s_q.fall;
   assign clock_half_period_out = s_q.half_end;
   assign clock_mode_strap_bits_out = s_q.strap;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_presc_rise;
      eff == CCMG_PRESC && osc_rise;
   endsequence

   sequence s_presc_quiet;
      eff == CCMG_PRESC && !osc_rise;
   endsequence

   property p_capture_strap;
      $rose(resetn_in) |-> s_q.strap == $past(clock_mode_strap_pins_in)
         && s_q.oscillator_watchdog_enable == $past(oscillator_watchdog_enable_in);
   endproperty
   a_capture_strap: assert property (p_capture_strap)
      else $error("strap levels not captured at reset release");

   property p_mode_held;
      $past(resetn_in) |-> $stable(s_q.strap) && $stable(s_q.oscillator_watchdog_enable);
   endproperty
   a_mode_held: assert property (p_mode_held)
      else $error("clock mode changed outside reset");

   property p_decode_int;
      eff == CCMG_PLL && s_q.strap == `CCMG_CODE_X4 |-> pll_if.win == 5'h4 && pll_if.halfs == 6'h10;
   endproperty
   a_decode_int: assert property (p_decode_int)
      else $error("times four code not decoded to four");

   property p_decode_frac;
      eff == CCMG_PLL && s_q.strap == `CCMG_CODE_X15 |-> pll_if.win == 5'h6 && pll_if.halfs == 6'h9;
   endproperty
   a_decode_frac: assert property (p_decode_frac)
      else $error("times one and a half code decoded wrongly");

   property p_presc_toggle;
      s_presc_rise |=> s_q.cpu != $past(s_q.cpu) ##1 s_q.cpu == $past(s_q.cpu);
   endproperty
   a_presc_toggle: assert property (p_presc_toggle)
      else $error("prescaler did not toggle once on an input rise");

   property p_presc_hold;
      s_presc_quiet |=> $stable(s_q.cpu);
   endproperty
   a_presc_hold: assert property (p_presc_hold)
      else $error("prescaler phase ended before a full input period");

   property p_direct_follow;
      eff == CCMG_DIRECT ##1 eff == CCMG_DIRECT |-> s_q.cpu == $past(oscillator_input_pin_in);
   endproperty
   a_direct_follow: assert property (p_direct_follow)
      else $error("direct drive does not follow the input");

   property p_watchdog_forces;
      !s_q.oscillator_watchdog_enable && s_q.strap != `CCMG_CODE_PRESC |-> eff == CCMG_DIRECT && !pll_if.en;
   endproperty
   a_watchdog_forces: assert property (p_watchdog_forces)
      else $error("low watchdog enable did not force direct drive");

   property p_pll_select;
      s_q.oscillator_watchdog_enable && s_q.strap != `CCMG_CODE_PRESC && s_q.strap != `CCMG_CODE_DIRECT |-> pll_if.en;
   endproperty
   a_pll_select: assert property (p_pll_select)
      else $error("multiplier not enabled for a multiplier code");

   property p_edge_flags;
      $changed(s_q.cpu) |-> s_q.half_end && s_q.rise == s_q.cpu && s_q.fall == !s_q.cpu;
   endproperty
   a_edge_flags: assert property (p_edge_flags)
      else $error("CPU clock edge not flagged");

   property p_half_count;
      $past(resetn_in) && s_q.half_end |-> s_q.half_cnt == HW'($past(s_q.half_cnt) + 1'b1);
   endproperty
   a_half_count: assert property (p_half_count)
      else $error("half-period counter missed an edge");
endmodule
`default_nettype wire

// *** sim/ccmg_osc_model.sv ***
// Oscillator and strap source standing at the far side of the clock generator
`default_nettype none
module ccmg_osc_model (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   // Oscillator shape in reference cycles, at least 2 each
   input  wire logic [4:0] hi_cyc_in,
   input  wire logic [4:0] lo_cyc_in,
   // Strap levels presented while reset is low
   input  wire logic [2:0] code_in,
   input  wire logic       owe_in,
   // Device pins
   output var  logic       osc_out,
   output var  logic [2:0] strap_out,
   output var  logic       owe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt_q = 5'h00;
   logic       osc_q = 1'b0;
   // Free-running oscillator, changed just after the reference edge
   always @(posedge ref_clk_in) begin
      if (cnt_q + 5'h01 >= (osc_q ? hi_cyc_in : lo_cyc_in)) begin
         osc_q <= ~osc_q;
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_q + 5'h01;
      end
   end
   assign osc_out = osc_q;
   // Defined straps in reset; afterwards the pins show the inverse, so a mode that follows them is caught
   assign strap_out = resetn_in ? ~code_in : code_in;
   assign owe_out   = resetn_in ? ~owe_in : owe_in;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench of the CPU clock mode generator
`default_nettype none
module tb import ccmg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in, resetn_in, rd, wr, owe_q, osc, owe_pin, wait_r;
   logic        cpu_clk, cpu_rise, cpu_fall, cpu_half, clk_prev;
   logic [4:0]  hi_q, lo_q;
   logic [2:0]  code_q, strap, strap_bits;
   logic [3:0]  addr, be;
   logic [31:0] wdata, rdata;
   int          n_mismatch, comparisons, rises, orises, n_pulse, hmin, hmax, dmax, smin, smax;

   ccmg_osc_model u_ccmg_osc_model (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hi_cyc_in(hi_q),
      .lo_cyc_in(lo_q), .code_in(code_q), .owe_in(owe_q), .osc_out(osc), .strap_out(strap), .owe_out(owe_pin));
   ccmg_top u_ccmg_top (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .oscillator_input_pin_in(osc),
      .clock_mode_strap_pins_in(strap), .oscillator_watchdog_enable_in(owe_pin), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .cpu_clk_out(cpu_clk), .cpu_rise_out(cpu_rise),
      .cpu_fall_out(cpu_fall), .clock_half_period_out(cpu_half), .clock_mode_strap_bits_out(strap_bits));

   // Reference clock, 25 ns
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon access: held until waitrequest is sampled low, data taken at that edge
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
      int i;
      @(posedge ref_clk_in);
      rd <= ~w; wr <= w; addr <= a; wdata <= d; be <= b;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk_in);
         if (wait_r === 1'b0) break;
      end
      q = rdata;
      rd <= 1'b0; wr <= 1'b0;
      if (i == 20) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   // Phase markers coincide with the level change they announce
   always @(posedge ref_clk_in) begin
      if (resetn_in === 1'b1) begin
         check("cpu_rise", 32'(cpu_rise), 32'(cpu_clk & ~clk_prev));
         check("cpu_fall", 32'(cpu_fall), 32'(~cpu_clk & clk_prev));
         check("half_pulse", 32'(cpu_half), 32'(cpu_rise | cpu_fall));
      end
      clk_prev <= cpu_clk;
   end

   // Counts edges and half-period lengths over a window
   task automatic measure(input int cyc);
      int len, prev, d;
      logic op;
      rises = 0; orises = 0; n_pulse = 0; hmin = 999; hmax = 0; dmax = 0; smin = 999; smax = 0;
      len = -1; prev = 0; op = osc;
      for (int k = 0; k < cyc; k++) begin
         @(posedge ref_clk_in);
         if (cpu_rise === 1'b1) rises++;
         if (osc && !op) orises++;
         op = osc;
         if (len >= 0) len++;
         if (cpu_half === 1'b1) begin
            n_pulse++;
            if (len > 0) begin
               hmin = (len < hmin) ? len : hmin;
               hmax = (len > hmax) ? len : hmax;
               if (prev > 0) begin
                  d = (len > prev) ? len - prev : prev - len;
                  dmax = (d > dmax) ? d : dmax;
                  smin = (len + prev < smin) ? len + prev : smin;
                  smax = (len + prev > smax) ? len + prev : smax;
               end
               prev = len;
            end
            len = 0;
         end
      end
   endtask

   // Reset with a strap code, let the clock settle, then judge rate and phases
   task automatic run_mode(input logic [2:0] c, input logic o);
      logic [31:0] q, h0, st;
      logic [1:0] m;
      int f2, e, dh;
      m = (c == 3'h1) ? 2'h2 : ((c == 3'h3 || !o) ? 2'h1 : 2'h0);
      case (c)
         3'h7: f2 = 8;
         3'h6: f2 = 6;
         3'h5: f2 = 4;
         3'h4: f2 = 10;
         3'h2: f2 = 3;
         default: f2 = 5;
      endcase
      @(posedge ref_clk_in);
      code_q <= c; owe_q <= o; resetn_in <= 1'b0;
      hi_q <= (m == 2'h0) ? 5'h0a : 5'h03;
      lo_q <= (m == 2'h0) ? 5'h0a : 5'h05;
      repeat (4) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      repeat ((m == 2'h0) ? 3000 : 50) @(posedge ref_clk_in);
      check("strap_bits", 32'(strap_bits), 32'(c));
      av(1'b0, 4'h4, 32'h0, 4'hf, st);
      check("status_code", 32'(st[3:0]), 32'({o, c}));
      check("status_mode", 32'(st[5:4]), 32'(m));
      av(1'b0, 4'h8, 32'h0, 4'hf, h0);
      measure(400);
      av(1'b0, 4'h8, 32'h0, 4'hf, q);
      dh = int'(16'(q - h0));
      check("half_count", 32'(dh >= n_pulse - 2 && dh <= n_pulse + 4), 32'h1);
      check("strap_hold", 32'(strap_bits), 32'(c));
      if (m == 2'h1) begin
         check("dir_rate", 32'(rises >= orises - 1 && rises <= orises + 1), 32'h1);
         check("dir_hmin", 32'(hmin), 32'd3);
         check("dir_hmax", 32'(hmax), 32'd5);
         check("dir_smin", 32'(smin), 32'd8);
         check("dir_smax", 32'(smax), 32'd8);
      end else if (m == 2'h2) begin
         check("pre_rate", 32'(2 * rises >= orises - 2 && 2 * rises <= orises + 2), 32'h1);
         check("pre_hmin", 32'(hmin), 32'd8);
         check("pre_hmax", 32'(hmax), 32'd8);
      end else begin
         e = 2 * rises - orises * f2;
         check("pll_rate", 32'(e <= f2 + 2 && e >= -(f2 + 2)), 32'h1);
         check("pll_lock", 32'(st[6]), 32'h1);
         av(1'b0, 4'h4, 32'h0, 4'hf, q);
         check("pll_locked", 32'(q[6]), 32'h1);
         check("pll_smooth", 32'(dmax <= 1), 32'h1);
      end
   endtask

   // Gain register: reset value, byte enable, read-only and unmapped places
   task automatic reg_test();
      logic [31:0] q, s;
      av(1'b0, 4'h0, 32'h0, 4'hf, q);
      check("gain_rst", 32'(q[1:0]), 32'h2);
      av(1'b1, 4'h0, 32'h3, 4'h0, q);
      av(1'b0, 4'h0, 32'h0, 4'hf, q);
      check("gain_be0", 32'(q[1:0]), 32'h2);
      av(1'b1, 4'h0, 32'h1, 4'h1, q);
      av(1'b0, 4'h0, 32'h0, 4'hf, q);
      check("gain_wr", 32'(q[1:0]), 32'h1);
      // Runs after code 000 with watchdog high, so the status low nibble is 8
      av(1'b0, 4'h4, 32'h0, 4'hf, s);
      check("status_pre", 32'(s[3:0]), 32'h8);
      av(1'b1, 4'h4, 32'h0, 4'hf, q);
      av(1'b0, 4'h4, 32'h0, 4'hf, q);
      check("status_ro", 32'(q[3:0]), 32'h8);
      av(1'b0, 4'hc, 32'h0, 4'hf, q);
      check("unmapped", q, 32'h0);
      av(1'b1, 4'h0, 32'h2, 4'h1, q);
   endtask

   // Main sequence: every strap code, then watchdog low over multiplier and prescaler codes
   initial begin
      resetn_in = 1'b0; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0; be = 4'h0; clk_prev = 1'b0;
      code_q = 3'h7; owe_q = 1'b1; hi_q = 5'h0a; lo_q = 5'h0a; n_mismatch = 0; comparisons = 0;
      repeat (15) @(posedge ref_clk_in);
      for (int i = 0; i < 10; i++) begin
         run_mode((i < 8) ? 3'(i) : ((i == 8) ? 3'h7 : 3'h1), i < 8);
         if (i == 0) reg_test();
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
